// ### shared/fabric_csr_pkg.sv
// shared constants, field layout and carrier types for the fabric register block
package fabric_csr_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADR_W = 12;
    localparam int DAT_W = 32;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_ACCESS_CMD  = 12'h1e0;
    localparam logic [11:0] OFS_ACCESS_WORD = 12'h1e4;
    localparam logic [11:0] OFS_ADDR_HIGH   = 12'h1f0;
    localparam logic [11:0] OFS_ADDR_LOW    = 12'h1f4;
    localparam logic [11:0] OFS_WIN_FIRST   = 12'h200;
    localparam logic [11:0] OFS_WIN_LAST    = 12'h2dc;
    localparam int          WIN_ENTRIES     = 56;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_ADDR_HIGH   = 16'hffff;
    localparam logic [31:0] RST_ADDR_LOW    = 32'hff0f_8000;
    localparam logic [47:0] RST_PAUSE_ADDR  = {RST_ADDR_HIGH, RST_ADDR_LOW};
    localparam logic [31:0] RST_WIN_DATA    = 32'h0000_0000;
    localparam logic [31:0] RST_WORD        = 32'h0000_0000;
    localparam logic [15:0] RST_CMD_ADDR    = 16'h0000;
    localparam logic [3:0]  RST_CMD_LANES   = 4'h0;
    localparam logic [3:0]  ALL_LANES       = 4'hf;

    // ----------------------------------------------------------------
    // command register field positions
    // ----------------------------------------------------------------
    localparam int CMD_BUSY_BIT = 31;
    localparam int CMD_RNW_BIT  = 30;
    localparam int CMD_BE_LSB   = 16;
    localparam int CMD_ADDR_LSB = 0;

    // ----------------------------------------------------------------
    // serial eeprom locations of the pause source address
    // ----------------------------------------------------------------
    localparam logic [7:0] EE_FIRST_LOC = 8'h01;
    localparam int         ADDR_BYTES   = 6;

    // ----------------------------------------------------------------
    // direct window: fabric register per word, in window order
    // ----------------------------------------------------------------
    localparam logic [15:0] WIN_MAP [0:WIN_ENTRIES-1] = '{
        16'h0001, 16'h0004,
        16'h0401, 16'h0440, 16'h0441, 16'h0480,
        16'h0801, 16'h0840, 16'h0841, 16'h0880,
        16'h0c01, 16'h0c40, 16'h0c41, 16'h0c80,
        16'h1800, 16'h1801, 16'h1802, 16'h1809, 16'h180b, 16'h180c,
        16'h1811, 16'h1812, 16'h1840, 16'h1841, 16'h1842, 16'h1843,
        16'h1845, 16'h1846, 16'h1847, 16'h1848, 16'h1849, 16'h184a,
        16'h184b, 16'h184d, 16'h1855, 16'h1856, 16'h1857, 16'h1880,
        16'h1c00, 16'h1c01, 16'h1c02, 16'h1c03, 16'h1c04, 16'h1c09,
        16'h1c0a, 16'h1c0c, 16'h1c0d, 16'h1c0e, 16'h1c0f, 16'h1c10,
        16'h1c11, 16'h1c12, 16'h1c13, 16'h1c14, 16'h1c15, 16'h1c20
    };

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [3:0]  lanes;
        logic [31:0] data;
    } fab_req_t;

    typedef struct packed {
        logic [7:0] loc;
        logic [7:0] value;
    } ee_byte_t;

endpackage : fabric_csr_pkg

// ### sim/fabric_csr_regs_monitor.sv
// port-level assertion checker for the fabric register bank
`timescale 1ns/1ps
module fabric_csr_regs_checker (
    input wire logic                             clk_i,
    input wire logic                             rst_i,
    input wire logic                             wb_cyc_i,
    input wire logic                             wb_stb_i,
    input wire logic                             wb_we_i,
    input wire logic [fabric_csr_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]                       wb_sel_i,
    input wire logic [fabric_csr_pkg::DAT_W-1:0] wb_dat_i,
    input wire logic [fabric_csr_pkg::DAT_W-1:0] wb_dat_o,
    input wire logic                             wb_ack_o,
    input wire logic                             init_done_i,
    input wire logic                             ee_valid_i,
    input wire fabric_csr_pkg::ee_byte_t         ee_i,
    input wire logic [47:0]                      pause_addr_o,
    input wire logic                             fab_valid_o,
    input wire fabric_csr_pkg::fab_req_t         fab_req_o,
    input wire logic                             fab_done_i
);
    import fabric_csr_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // reset delayed one edge, so the first edge after release is visible
    logic rst_q;
    always_ff @(posedge clk_i) rst_q <= rst_i;
    wire logic take_w  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic win_w   = wb_adr_i >= OFS_WIN_FIRST && wb_adr_i <= OFS_WIN_LAST;
    wire logic start_w = take_w && wb_we_i && ((win_w && wb_adr_i[1:0] == 2'b00) || wb_adr_i == OFS_ACCESS_CMD);
    sequence s_win_wr;
        take_w && wb_we_i && win_w && wb_adr_i[1:0] == 2'b00 && !fab_valid_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_ONCE: assert property (take_w |=> s_ack_pulse)
        else $error("ack not a single pulse after request");
    AST_RST_VALUES: assert property (rst_q && !rst_i |-> pause_addr_o == RST_PAUSE_ADDR && !fab_valid_o)
        else $error("reset values wrong after release");
    AST_WIN_START: assert property (s_win_wr |=> fab_valid_o && fab_req_o.lanes == ALL_LANES)
        else $error("window write did not start a full-lane fabric write");
    AST_WIN_DATA: assert property (s_win_wr |=> fab_req_o.data == $past(wb_dat_i))
        else $error("fabric data differs from window write");
    AST_MAP_FIRST: assert property (s_win_wr ##0 wb_adr_i == 12'h200 |=> fab_req_o.addr == 16'h0001)
        else $error("offset 200 mapped wrongly");
    AST_MAP_PORT0: assert property (s_win_wr ##0 wb_adr_i == 12'h208 |=> fab_req_o.addr == 16'h0401)
        else $error("offset 208 mapped wrongly");
    AST_BUSY_HOLD: assert property (fab_valid_o && !fab_done_i |=> fab_valid_o && $stable(fab_req_o))
        else $error("busy dropped or request moved before completion");
    AST_BUSY_CLEAR: assert property (fab_valid_o && fab_done_i |=> !fab_valid_o)
        else $error("busy not cleared after completion");
    AST_WIN_RD_ZERO: assert property (take_w && !wb_we_i && win_w |=> wb_dat_o == 32'h0000_0000)
        else $error("window read returned data");
    AST_NO_SPURIOUS: assert property (!fab_valid_o && !start_w |=> !fab_valid_o)
        else $error("fabric write started without a mapped request");
    AST_LOAD_FIRST: assert property (ee_valid_i && !init_done_i && ee_i.loc == 8'h01
        |=> pause_addr_o[7:0] == $past(ee_i.value))
        else $error("loader byte 1 misplaced");
    AST_LOAD_LAST: assert property (ee_valid_i && !init_done_i && ee_i.loc == 8'h06
        |=> pause_addr_o[47:40] == $past(ee_i.value))
        else $error("loader byte 6 misplaced");
endmodule : fabric_csr_regs_checker

bind fabric_csr_regs fabric_csr_regs_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .init_done_i(init_done_i), .ee_valid_i(ee_valid_i), .ee_i(ee_i),
    .pause_addr_o(pause_addr_o), .fab_valid_o(fab_valid_o), .fab_req_o(fab_req_o), .fab_done_i(fab_done_i));

// ### sim/fabric_space_model.sv
// behavioural fabric register space answering direct writes
`timescale 1ns/1ps
module fabric_space_model (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     fab_valid_i,
    input  wire fabric_csr_pkg::fab_req_t fab_req_i,
    input  wire logic [3:0]               delay_i,
    output logic                          fab_done_o,
    output fabric_csr_pkg::fab_req_t      last_o,
    output logic [7:0]                    writes_o
);
    import fabric_csr_pkg::*;
    logic [3:0] wait_q;
    // wait delay_i cycles, then one completion pulse; masked lanes stay zero
    always_ff @(posedge clk_i) begin
        fab_done_o <= 1'b0;
        if (rst_i) begin
            wait_q   <= 4'h0;
            writes_o <= 8'h00;
            last_o   <= '0;
        end else if (fab_valid_i && !fab_done_o) begin
            if (wait_q >= delay_i) begin
                fab_done_o  <= 1'b1;
                wait_q      <= 4'h0;
                last_o      <= fab_req_i;
                last_o.data <= fab_req_i.data & {{8{fab_req_i.lanes[3]}}, {8{fab_req_i.lanes[2]}},
                               {8{fab_req_i.lanes[1]}}, {8{fab_req_i.lanes[0]}}};
                writes_o    <= writes_o + 8'h01;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule : fabric_space_model

// ### sim/tb.sv
// self-checking bench for the fabric register bank
`timescale 1ns/1ps
module tb;
    import fabric_csr_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        init_done = 1'b0, ee_valid = 1'b0, wb_ack, fab_valid, fab_done;
    logic [11:0] adr = 12'h000;
    logic [3:0]  sel = 4'h0, delay = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, wb_dat, rd, d;
    logic [47:0] pause_addr, mac;
    logic [51:0] exp_w;
    logic [51:0] exp_q [$];
    logic [7:0]  writes;
    logic [15:0] lfsr_q = 16'hcbd7; // seed 52183
    ee_byte_t    ee = '0;
    fab_req_t    fab_req, last;
    int          err_total = 0, checked = 0;
    always #2 clk_i = ~clk_i;
    fabric_csr_regs u_fabric_csr_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
        .init_done_i(init_done), .ee_valid_i(ee_valid), .ee_i(ee), .pause_addr_o(pause_addr),
        .fab_valid_o(fab_valid), .fab_req_o(fab_req), .fab_done_i(fab_done));
    fabric_space_model u_fabric_space_model (.clk_i(clk_i), .rst_i(rst_i), .fab_valid_i(fab_valid),
        .fab_req_i(fab_req), .delay_i(delay), .fab_done_o(fab_done), .last_o(last), .writes_o(writes));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("mismatches=%0d comparisons=%0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    // one classic cycle; hold everything until ack is sampled high
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] v);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hf;
        wdat <= v;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 40);
        rd = wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 40) begin
            err_total++;
            final_report();
        end
    endtask : wb
    // bounded wait for the pending fabric write to finish
    task automatic wait_idle();
        int n;
        n = 0;
        while (fab_valid !== 1'b0 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 40) begin
            err_total++;
            final_report();
        end
    endtask : wait_idle
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, OFS_ADDR_HIGH, 0);
        chk(rd, 32'h0000_ffff);
        wb(1, OFS_ADDR_LOW, 32'h1234_5678);
        wb(0, OFS_ADDR_LOW, 0);
        chk(rd, 32'hff0f_8000);
        // loader bytes in ascending location order
        for (int i = 0; i < 6; i++) begin
            lfsr_q = lfsr(lfsr_q);
            mac[8*i +: 8] = lfsr_q[7:0];
            @(posedge clk_i);
            ee_valid <= 1'b1;
            ee       <= '{loc: 8'(i + 1), value: lfsr_q[7:0]};
        end
        @(posedge clk_i);
        ee_valid <= 1'b0;
        @(posedge clk_i);
        chk(pause_addr, mac);
        init_done <= 1'b1;
        lfsr_q = lfsr(lfsr_q);
        mac = {lfsr_q, lfsr_q ^ 16'h5a5a, ~lfsr_q};
        wb(1, OFS_ADDR_LOW, mac[31:0]);
        wb(1, OFS_ADDR_HIGH, {16'hffff, mac[47:32]});
        wb(0, OFS_ADDR_HIGH, 0);
        chk(rd, {16'h0000, mac[47:32]});
        chk(pause_addr, mac);
        // every window word, alternating prompt and slow completion
        for (int i = 0; i < WIN_ENTRIES; i++) begin
            lfsr_q = lfsr(lfsr_q);
            d = {lfsr_q, ~lfsr_q};
            delay <= (i % 2 == 1) ? 4'h9 : 4'h0;
            exp_q.push_back({WIN_MAP[i], 4'hf, d});
            wb(1, OFS_WIN_FIRST + 12'(4 * i), d);
            if (i % 2 == 1) begin
                wb(0, OFS_ACCESS_CMD, 0);
                chk(rd, {2'b10, 10'h000, 4'hf, WIN_MAP[i]});
                wb(1, OFS_WIN_FIRST, 32'h0bad_0bad);
            end
            wait_idle();
            exp_w = exp_q.pop_front();
            chk(last, exp_w);
            wb(0, OFS_ACCESS_CMD, 0);
            chk(rd[31:30], 2'b00);
            wb(0, OFS_WIN_FIRST + 12'(4 * i), 0);
            chk(rd, 32'h0000_0000);
        end
        chk(writes, 8'(WIN_ENTRIES));
        // misaligned and outside words must not start anything
        wb(1, 12'h202, 32'h1111_2222);
        wb(1, 12'h2e0, 32'h3333_4444);
        repeat (3) @(posedge clk_i);
        chk({fab_valid, writes}, {1'b0, 8'(WIN_ENTRIES)});
        // indirect write through the command register, two lanes only
        lfsr_q = lfsr(lfsr_q);
        d = {~lfsr_q, lfsr_q};
        wb(1, OFS_ACCESS_WORD, d);
        wb(0, OFS_ACCESS_WORD, 0);
        chk(rd, d);
        wb(1, OFS_ACCESS_CMD, {2'b10, 10'h000, 4'h5, 16'h1234});
        wb(0, OFS_ACCESS_CMD, 0);
        chk(rd, {2'b10, 10'h000, 4'h5, 16'h1234});
        wait_idle();
        chk(last, {16'h1234, 4'h5, d & 32'h00ff_00ff});
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(pause_addr, 48'hffff_ff0f_8000);
        final_report();
    end
    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        final_report();
    end
endmodule : tb

// ### verilog/fabric_csr_regs.sv
// wishbone register bank: pause source address and direct fabric write window
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - high register bits 15:0 hold address 47:32, reset ffff; upper bits read zero
// - low register holds address 31:0, full width read/write, reset ff0f8000
// - loader fills both address registers at power-on when eeprom is programmed
// - eeprom bytes 01h..04h go to low register bytes 0..3
// - eeprom byte 05h to high bits 7:0, byte 06h to bits 15:8
// - host may overwrite address registers after init; new value used at once
// - first received address byte is low bits 7:0, sixth is high 15:8
// - writes to 200h..2dch are direct fabric writes; window is write-only
// - window write loads mapped address, all lanes, clears read flag, sets busy
// - busy clears only when the fabric write has completed
// - window never returns fabric read data
// - 200h maps to fabric 0001h, 204h to fabric 0004h
// - each port has four words: rx, tx, flow control, irq mask
// - window data is 32-bit write-only, reset zero, delivered to fabric
// - byte-lane selects 19:16 gate fabric bytes 3..0
// - command bits 15:0 carry the fabric target address
module fabric_csr_regs (
    input  wire logic                             clk_i,
    input  wire logic                             rst_i,
    // wishbone classic slave
    input  wire logic                             wb_cyc_i,
    input  wire logic                             wb_stb_i,
    input  wire logic                             wb_we_i,
    input  wire logic [fabric_csr_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                       wb_sel_i,
    input  wire logic [fabric_csr_pkg::DAT_W-1:0] wb_dat_i,
    output logic      [fabric_csr_pkg::DAT_W-1:0] wb_dat_o,
    output logic                                  wb_ack_o,
    // eeprom loader byte stream
    input  wire logic                             init_done_i,
    input  wire logic                             ee_valid_i,
    input  wire fabric_csr_pkg::ee_byte_t         ee_i,
    // pause frame source address to the fabric macs
    output logic      [47:0]                      pause_addr_o,
    // fabric register write port
    output logic                                  fab_valid_o,
    output fabric_csr_pkg::fab_req_t              fab_req_o,
    input  wire logic                             fab_done_i
);
    import fabric_csr_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]       addr_byte_q [0:ADDR_BYTES-1];
    logic [15:0]      cmd_addr_q;
    logic [3:0]       cmd_lanes_q;
    logic             cmd_rnw_q;
    logic             busy_q;
    logic [31:0]      word_q;
    logic             fab_valid_q;
    fab_req_t         fab_req_q;
    logic             ack_q;
    logic [31:0]      dat_q;

    // ----------------------------------------------------------------
    // bus request decode
    // ----------------------------------------------------------------
    // one request per classic cycle: a new request is held off while ack is high,
    // so a held strobe never counts twice
    wire logic        req;
    wire logic        wr;
    wire logic        rd;
    wire logic        sel_high;
    wire logic        sel_low;
    wire logic        sel_cmd;
    wire logic        sel_word;
    wire logic        win_hit;
    wire logic        win_mapped;
    wire logic [15:0] win_fab_addr;

    assign req      = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr       = req && wb_we_i;
    assign rd       = req && !wb_we_i;
    assign sel_high = (wb_adr_i == OFS_ADDR_HIGH);
    assign sel_low  = (wb_adr_i == OFS_ADDR_LOW);
    assign sel_cmd  = (wb_adr_i == OFS_ACCESS_CMD);
    assign sel_word = (wb_adr_i == OFS_ACCESS_WORD);

    // window translation lives in its own table module
    fabric_direct_map u_map (
        .offset_i      (wb_adr_i),
        .in_window_o   (win_hit),
        .mapped_o      (win_mapped),
        .fabric_addr_o (win_fab_addr)
    );

    // ----------------------------------------------------------------
    // write qualification
    // ----------------------------------------------------------------
    // address registers stay with the loader until init has finished
    wire logic        host_addr_ok;
    wire logic        win_start;
    wire logic        cmd_wr;
    wire logic        cmd_start;
    wire logic        word_wr;
    wire logic        fab_finish;

    assign host_addr_ok = init_done_i;
    // a pending fabric write is never disturbed; unmapped words do nothing
    assign win_start    = wr && win_mapped && !busy_q;
    assign cmd_wr       = wr && sel_cmd && !busy_q;
    assign cmd_start    = cmd_wr && wb_dat_i[CMD_BUSY_BIT] && !wb_dat_i[CMD_RNW_BIT];
    assign word_wr      = wr && sel_word && !busy_q;
    assign fab_finish   = busy_q && fab_done_i;

    // ----------------------------------------------------------------
    // pause source address bytes
    // ----------------------------------------------------------------
    // byte k is received k-th on the wire; bytes 0..3 sit in the low
    // register, 4..5 in the high register, eeprom location 1+k feeds it
    genvar k;
    generate
        for (k = 0; k < ADDR_BYTES; k++) begin : g_addr_byte
            localparam int         LANE = k % 4;
            localparam logic [7:0] LOC  = EE_FIRST_LOC + 8'(k);
            wire logic             reg_sel;
            wire logic             host_wr;
            wire logic             ee_wr;

            assign reg_sel = (k < 4) ? sel_low : sel_high;
            assign host_wr = wr && reg_sel && wb_sel_i[LANE] && host_addr_ok;
            assign ee_wr   = ee_valid_i && !init_done_i && (ee_i.loc == LOC);

            // host after init, loader before; the two never overlap
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    addr_byte_q[k] <= RST_PAUSE_ADDR[8*k +: 8];
                end else if (host_wr) begin
                    addr_byte_q[k] <= wb_dat_i[8*LANE +: 8];
                end else if (ee_wr) begin
                    addr_byte_q[k] <= ee_i.value;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // command register: target address, lanes, read flag, busy
    // ----------------------------------------------------------------
    // window write overrides whatever software left in the command fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_addr_q  <= RST_CMD_ADDR;
            cmd_lanes_q <= RST_CMD_LANES;
            cmd_rnw_q   <= 1'b0;
        end else if (win_start) begin
            cmd_addr_q  <= win_fab_addr;
            cmd_lanes_q <= ALL_LANES;
            cmd_rnw_q   <= 1'b0;
        end else if (cmd_wr) begin
            cmd_addr_q  <= wb_dat_i[CMD_ADDR_LSB +: 16];
            cmd_lanes_q <= wb_dat_i[CMD_BE_LSB +: 4];
            cmd_rnw_q   <= wb_dat_i[CMD_RNW_BIT];
        end
    end

    // busy: starts are refused while set, so set and clear never collide
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
        end else if (win_start || cmd_start) begin
            busy_q <= 1'b1;
        end else if (fab_finish) begin
            busy_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // data holding registers
    // ----------------------------------------------------------------
    // indirect write word, used by command-register started writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_q <= RST_WORD;
        end else if (word_wr) begin
            word_q <= wb_dat_i;
        end
    end

    // ----------------------------------------------------------------
    // fabric write request
    // ----------------------------------------------------------------
    // request is a level that stands until the fabric reports done;
    // the lane selects travel with it so the fabric skips clear bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fab_valid_q <= 1'b0;
            fab_req_q   <= '{addr: RST_CMD_ADDR, lanes: RST_CMD_LANES, data: RST_WIN_DATA};
        end else if (win_start) begin
            fab_valid_q <= 1'b1;
            fab_req_q   <= '{addr: win_fab_addr, lanes: ALL_LANES, data: wb_dat_i};
        end else if (cmd_start) begin
            fab_valid_q <= 1'b1;
            fab_req_q   <= '{addr:  wb_dat_i[CMD_ADDR_LSB +: 16],
                             lanes: wb_dat_i[CMD_BE_LSB +: 4],
                             data:  word_q};
        end else if (fab_finish) begin
            fab_valid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read data selection
    // ----------------------------------------------------------------
    // window and unknown offsets read as zero; the window has no read
    // path, and a command with the read flag set starts no fabric access
    wire logic [31:0] high_word;
    wire logic [31:0] low_word;
    wire logic [31:0] cmd_word;
    wire logic [31:0] rd_data;

    assign high_word = {16'h0000, addr_byte_q[5], addr_byte_q[4]};
    assign low_word  = {addr_byte_q[3], addr_byte_q[2], addr_byte_q[1], addr_byte_q[0]};
    assign cmd_word  = {busy_q, cmd_rnw_q, 10'h000, cmd_lanes_q, cmd_addr_q};
    assign rd_data   = sel_high ? high_word :
                       sel_low  ? low_word  :
                       sel_cmd  ? cmd_word  :
                       sel_word ? word_q    :
                                  32'h0000_0000;

    // ----------------------------------------------------------------
    // bus answer
    // ----------------------------------------------------------------
    // every request is acked one cycle after it is taken, unmapped ones
    // too, so a stray access can never hang the master
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            dat_q <= rd ? rd_data : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign wb_ack_o     = ack_q;
    assign wb_dat_o     = dat_q;
    assign fab_valid_o  = fab_valid_q;
    assign fab_req_o    = fab_req_q;
    assign pause_addr_o = {addr_byte_q[5], addr_byte_q[4], addr_byte_q[3],
                           addr_byte_q[2], addr_byte_q[1], addr_byte_q[0]};

endmodule : fabric_csr_regs

// ### verilog/fabric_direct_map.sv
// window offset to fabric register translation
`timescale 1ns/1ps

module fabric_direct_map (
    input  wire logic [fabric_csr_pkg::ADR_W-1:0] offset_i,
    output wire logic                             in_window_o,
    output wire logic                             mapped_o,
    output wire logic [15:0]                      fabric_addr_o
);
    import fabric_csr_pkg::*;

    // ----------------------------------------------------------------
    // window decode
    // ----------------------------------------------------------------
    // word index inside the window; only meaningful while in range
    wire logic [ADR_W-1:0] rel;
    wire logic [5:0]       index;
    wire logic             aligned;

    assign rel         = offset_i - OFS_WIN_FIRST;
    assign index       = rel[7:2];
    assign aligned     = (offset_i[1:0] == 2'b00);
    assign in_window_o = (offset_i >= OFS_WIN_FIRST) && (offset_i <= OFS_WIN_LAST);

    // misaligned or beyond-table words have no entry
    assign mapped_o      = in_window_o && aligned && (32'(index) < WIN_ENTRIES);
    assign fabric_addr_o = mapped_o ? WIN_MAP[index] : 16'h0000;

endmodule : fabric_direct_map
